// *** rx_link_status.sv ***
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "rx_link_cfg.svh"
module rx_link_status
    import rx_link_pkg::*;
#(
    parameter int M           = 2,
    parameter int S           = 1,
    parameter int WM          = 2,
    parameter int N           = 12,
    parameter int CS          = 1,
    parameter int LEMC_PERIOD = 32,
    parameter int HDR_GOOD    = 64
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    receive_reset_low,
    input  wire logic                    lane_header_ok,
    input  wire logic                    lane_mb_marker,
    input  wire logic                    sysref_in,
    input  wire logic                    timestamp_marker_in,
    input  wire logic [M*S*WM*N-1:0]     raw_samples,
    input  wire logic [M*S*WM*CS-1:0]    raw_control,
    input  wire logic                    raw_valid,
    input  wire logic                    checksum_detect,
    input  wire logic                    parity_detect,
    output logic                         header_lock_flag,
    output logic                         multiblock_lock_flag,
    output logic                         lanes_aligned_flag,
    output logic                         error_interrupt,
    output logic                         checksum_error,
    output logic                         command_parity_error,
    output logic                         ramp_mismatch,
    output logic [M*S*WM*N-1:0]          sample_out_bus,
    output logic [M*S*WM*CS-1:0]         control_bits_out,
    output logic                         sample_out_valid,
    input  wire logic                    sample_out_ready,
    input  wire logic [11:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [11:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    localparam int NS = M * S * WM;
    localparam int LW = $clog2(LEMC_PERIOD);
    localparam int HW = $clog2(HDR_GOOD + 1);
    localparam logic [LW-1:0] LEMC_LAST = LW'(LEMC_PERIOD - 1);
    localparam logic [HW-1:0] HDR_DONE  = HW'(HDR_GOOD);

    // refuse shapes the logic cannot serve
    if (N < 2 || LEMC_PERIOD < 2 || (LEMC_PERIOD & (LEMC_PERIOD - 1)) != 0 || HDR_GOOD < 1) begin : g_bad
        $error("rx_link_status: unsupported parameters");
    end

    // ----------------------------------------------------------------
    // pin synchronisers and edges
    // ----------------------------------------------------------------
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    wire        rx_rst_n     = aresetn & receive_reset_low;
    wire        hdr_ok       = sync2_q[0];
    wire        mb_marker    = sync2_q[1] & ~sync3_q[1];
    wire        sysref_rise  = sync2_q[2] & ~sync3_q[2];
    wire        tstamp_rise  = sync2_q[3] & ~sync3_q[3];

    // two flops before any use, third only for edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
        end else begin
            sync1_q <= {timestamp_marker_in, sysref_in, lane_mb_marker, lane_header_ok};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // ----------------------------------------------------------------
    // local multiblock counter and sysref checks
    // ----------------------------------------------------------------
    logic [LW-1:0] lemc_q;
    logic          sysref_seen_q;
    wire           lemc_boundary = (lemc_q == '0);
    wire           phase_err     = sysref_rise & sysref_seen_q & (lemc_q != LEMC_LAST);

    // every sysref edge restarts the counter
    always_ff @(posedge aclk) begin
        if (!rx_rst_n) begin
            lemc_q        <= '0;
            sysref_seen_q <= 1'b0;
        end else begin
            lemc_q        <= sysref_rise ? '0 : lemc_q + 1'b1;
            sysref_seen_q <= sysref_seen_q | sysref_rise;
        end
    end

    // ----------------------------------------------------------------
    // alignment state machine
    // ----------------------------------------------------------------
    link_state_e state_q;
    link_state_e state_d;
    logic [HW-1:0] hdr_cnt_q;
    logic [8:0]    rbd_run_q;
    logic [8:0]    rbd_count_q;
    link_flags_s   flags_q;
    wire           locked    = (state_q != st_reset) && (state_q != st_hdr);
    wire           hdr_loss  = locked & ~hdr_ok;

    // next state: header search, multiblock search, boundary wait, data
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_reset: state_d = st_hdr;
            st_hdr:   if (hdr_cnt_q == HDR_DONE) state_d = st_mb;
            st_mb:    if (!hdr_ok) state_d = st_hdr;
                      else if (mb_marker) state_d = st_wait;
            st_wait:  if (!hdr_ok) state_d = st_hdr;
                      else if (lemc_boundary) state_d = st_data;
            st_data:  if (!hdr_ok) state_d = st_hdr;
            default:  state_d = st_reset;
        endcase
    end

    // state, header run length and release delay
    always_ff @(posedge aclk) begin
        if (!rx_rst_n) begin
            state_q     <= st_reset;
            hdr_cnt_q   <= '0;
            rbd_run_q   <= 9'h000;
            rbd_count_q <= 9'h000;
        end else begin
            state_q   <= state_d;
            hdr_cnt_q <= (state_q == st_hdr && hdr_ok && hdr_cnt_q != HDR_DONE) ? hdr_cnt_q + 1'b1 :
                         (state_q == st_hdr && hdr_ok) ? hdr_cnt_q : '0;
            if (state_q != st_wait) begin
                rbd_run_q <= 9'h000;
            end else if (rbd_run_q != 9'h1ff) begin
                rbd_run_q <= rbd_run_q + 1'b1;
            end
            if (state_q == st_wait && state_d == st_data) begin
                rbd_count_q <= rbd_run_q;
            end
        end
    end

    // status flags follow the state one edge later; header lock rises on the same edge as the entry to st_mb
    always_ff @(posedge aclk) begin
        if (!rx_rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q.header_lock <= locked | (state_d == st_mb);
            flags_q.mb_lock     <= (state_q == st_wait) | (state_q == st_data);
            flags_q.aligned     <= (state_q == st_data);
        end
    end

    // ----------------------------------------------------------------
    // sample stream, ramp checker, latency counter
    // ----------------------------------------------------------------
    logic [N-1:0] last_q;
    logic         ramp_q;
    logic         ramp_armed_q;
    logic         ramp_en_q;
    logic         ramp_clr;
    logic [NS-1:0] miss;
    logic [NS-1:0] lsbs;
    wire          take     = (state_q == st_data) & raw_valid & (~sample_out_valid | sample_out_ready);
    wire          ramp_hit = take & ramp_en_q & (|miss);

    // expected ramp: each sample one above its predecessor
    for (genvar i = 0; i < NS; i++) begin : g_smp
        wire [N-1:0] cur  = raw_samples[i*N +: N];
        wire [N-1:0] prev = (i == 0) ? last_q : raw_samples[(i == 0 ? 0 : i-1)*N +: N];
        assign miss[i] = (cur != prev + 1'b1) & ramp_armed_q;
        assign lsbs[i] = sample_out_bus[i*N];
    end


    // output register holds while the consumer stalls in st_data; valid drops once the state leaves st_data
    always_ff @(posedge aclk) begin
        if (!rx_rst_n) begin
            sample_out_valid <= 1'b0;
            sample_out_bus   <= '0;
            control_bits_out <= '0;
            last_q           <= '0;
            ramp_armed_q     <= 1'b0;
            ramp_q           <= 1'b0;
        end else begin
            if (take) begin
                sample_out_valid <= 1'b1;
                sample_out_bus   <= raw_samples;
                control_bits_out <= raw_control;
                last_q           <= raw_samples[(NS-1)*N +: N];
                ramp_armed_q     <= ramp_en_q;
            end else if (sample_out_ready || state_q != st_data) begin
                sample_out_valid <= 1'b0;
            end
            ramp_q <= ramp_hit | (ramp_q & ~ramp_clr);
        end
    end

    logic       lat_run_q;
    logic       lat_done_q;
    logic [15:0] lat_cnt_q;
    wire        lat_hit = lat_run_q & sample_out_valid & (|lsbs);

    // link clocks from timestamp edge to first marked sample
    always_ff @(posedge aclk) begin
        if (!rx_rst_n) begin
            lat_run_q  <= 1'b0;
            lat_done_q <= 1'b0;
            lat_cnt_q  <= 16'h0000;
        end else if (tstamp_rise && !lat_run_q) begin
            lat_run_q  <= 1'b1;
            lat_done_q <= 1'b0;
            lat_cnt_q  <= 16'h0000;
        end else if (lat_hit) begin
            lat_run_q  <= 1'b0;
            lat_done_q <= 1'b1;
        end else if (lat_run_q && lat_cnt_q != 16'hffff) begin
            lat_cnt_q  <= lat_cnt_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // error sources and interrupt
    // ----------------------------------------------------------------
    error_bits_s err_q;
    logic [4:0]  err_en_q;
    logic        singledet_q;
    wire   error_bits_s err_set = '{ramp_mismatch: ramp_hit, header_loss: hdr_loss,
                                    parity: parity_detect, checksum: checksum_detect,
                                    sysref_phase: phase_err};

    // sticky errors, one-cycle error pulses, masked interrupt
    always_ff @(posedge aclk) begin
        if (!rx_rst_n) begin
            err_q                <= '0;
            checksum_error       <= 1'b0;
            command_parity_error <= 1'b0;
            error_interrupt      <= 1'b0;
        end else begin
            err_q                <= err_q | err_set;
            checksum_error       <= checksum_detect;
            command_parity_error <= parity_detect;
            error_interrupt      <= |(err_q & err_en_q);
        end
    end

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    wire        wr_go   = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
    wire        rd_go   = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
    wire        wr_sref = wr_go & (s_axi_awaddr == `OFS_SYSREF_CONTROL) & s_axi_wstrb[0];
    wire        wr_en   = wr_go & (s_axi_awaddr == `OFS_ERROR_ENABLE) & s_axi_wstrb[0];
    wire        wr_test = wr_go & (s_axi_awaddr == `OFS_TEST_CONTROL) & s_axi_wstrb[0];
    assign      ramp_clr = wr_test & s_axi_wdata[1];
    wire        wr_hit  = (s_axi_awaddr == `OFS_SYSREF_CONTROL) | (s_axi_awaddr == `OFS_ERROR_ENABLE) |
                          (s_axi_awaddr == `OFS_TEST_CONTROL);
    wire        rd_hit  = (s_axi_araddr == `OFS_SYSREF_CONTROL) | (s_axi_araddr == `OFS_ERROR_STATUS) |
                          (s_axi_araddr == `OFS_ERROR_ENABLE) | (s_axi_araddr == `OFS_TEST_CONTROL) |
                          (s_axi_araddr == `OFS_LINK_STATUS) | (s_axi_araddr == `OFS_LATENCY);
    wire [31:0] st_word = {13'h0000, rbd_count_q, 3'h0, state_q, lat_done_q, flags_q};
    wire [31:0] rd_word =
        (s_axi_araddr == `OFS_SYSREF_CONTROL) ? {29'h0, singledet_q, 2'h0} :
        (s_axi_araddr == `OFS_ERROR_STATUS)   ? {27'h0, err_q} :
        (s_axi_araddr == `OFS_ERROR_ENABLE)   ? {27'h0, err_en_q} :
        (s_axi_araddr == `OFS_TEST_CONTROL)   ? {31'h0, ramp_en_q} :
        (s_axi_araddr == `OFS_LINK_STATUS)    ? st_word :
        (s_axi_araddr == `OFS_LATENCY)        ? {16'h0000, lat_cnt_q} : 32'h0;

    // control registers; a sysref edge beats a re-arm write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_en_q    <= `ERROR_ENABLE_RST;
            ramp_en_q   <= 1'b0;
            singledet_q <= 1'b1;
        end else begin
            if (wr_en) err_en_q <= s_axi_wdata[4:0];
            if (wr_test) ramp_en_q <= s_axi_wdata[0];
            if (sysref_rise) singledet_q <= 1'b0;
            else if (wr_sref && s_axi_wdata[`SINGLEDET_BIT]) singledet_q <= 1'b1;
        end
    end

    // write channel: address and data taken together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready  <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign header_lock_flag     = flags_q.header_lock;
    assign multiblock_lock_flag = flags_q.mb_lock;
    assign lanes_aligned_flag   = flags_q.aligned;
    assign ramp_mismatch        = ramp_q;
endmodule
`default_nettype wire

// *** rx_link_cfg.svh ***
// Operation
// - after receive reset release, search lanes for the 2-bit sync header stream
// - header lock rises only after receive reset release and header alignment
// - multiblock lock rises only after header lock
// - lanes aligned rises after multiblock lock and the next local multiblock boundary
// - on a clean link multiblock lock stays high, no invalid multiblock reported
// - error interrupt stays low while no enabled error exists; defaults suffice
// - sample bus width M*S*WM*N, control bus width M*S*WM*CS
// - in data phase receiver asserts valid, consumer asserts ready each frame
// - every SYSREF pulse is checked, not only the first; the code checks each edge after the first and never checks the first
// - single-detect at bit 2 of offset 0x54 reads zero after first SYSREF edge
// - SYSREF versus multiblock phase error at bit 0 of offset 0x60
// - release-delay count readable at bits 18:10 of offset 0x80
// - each captured SYSREF restarts the local multiblock counter
// - release-delay count repeats within 1 to 2 link clocks across resets
// - count link clocks from timestamp marker to first sample with LSB OR set
// - latency count repeats within 1 to 2 cycles over 10 power cycles; the testbench compares two runs around one receive reset
// - ramp checker compares samples to expected ramp, flags mismatch
// - checksum and parity errors pulse; error register reads zero when clean
`ifndef RX_LINK_CFG_SVH
`define RX_LINK_CFG_SVH
`define OFS_SYSREF_CONTROL 12'h054
`define OFS_ERROR_STATUS   12'h060
`define OFS_ERROR_ENABLE   12'h064
`define OFS_TEST_CONTROL   12'h068
`define OFS_LINK_STATUS    12'h080
`define OFS_LATENCY        12'h084
`define SINGLEDET_BIT      2
`define RBD_LSB            10
`define RBD_MSB            18
`define ERROR_ENABLE_RST   5'h1f
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// *** rx_link_pkg.sv ***
package rx_link_pkg;
    typedef enum logic [2:0] {
        st_reset = 3'b000,
        st_hdr   = 3'b001,
        st_mb    = 3'b010,
        st_wait  = 3'b011,
        st_data  = 3'b100
    } link_state_e;

    typedef struct packed {
        logic header_lock;
        logic mb_lock;
        logic aligned;
    } link_flags_s;

    typedef struct packed {
        logic ramp_mismatch;
        logic header_loss;
        logic parity;
        logic checksum;
        logic sysref_phase;
    } error_bits_s;
endpackage

// *** rx_link_status_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker for the receive link block
// ----------------------------------------
module rx_link_checker #(
    parameter int W = 48
) (
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         receive_reset_low,
    input wire logic [W-1:0] raw_samples,
    input wire logic         raw_valid,
    input wire logic         checksum_detect,
    input wire logic         parity_detect,
    input wire logic         header_lock_flag,
    input wire logic         multiblock_lock_flag,
    input wire logic         lanes_aligned_flag,
    input wire logic         error_interrupt,
    input wire logic         checksum_error,
    input wire logic         command_parity_error,
    input wire logic [W-1:0] sample_out_bus,
    input wire logic         sample_out_valid,
    input wire logic         sample_out_ready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // lock sequence and reset behaviour
    property p_quiet; !receive_reset_low |=> !header_lock_flag && !multiblock_lock_flag
        && !lanes_aligned_flag && !sample_out_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("flag or valid high in receive reset");
    property p_hdr; $rose(header_lock_flag) |-> $past(receive_reset_low) && $past(receive_reset_low, 4); endproperty
    a_hdr: assert property (p_hdr) else $error("header lock too soon");
    property p_mb; $rose(multiblock_lock_flag) |-> $past(header_lock_flag); endproperty
    a_mb: assert property (p_mb) else $error("multiblock lock before header lock");
    property p_align; $rose(lanes_aligned_flag) |-> $past(multiblock_lock_flag); endproperty
    a_align: assert property (p_align) else $error("aligned before multiblock lock");

    // stream handshake
    property p_hold; sample_out_valid && !sample_out_ready && receive_reset_low
        |=> sample_out_valid && $stable(sample_out_bus); endproperty
    a_hold: assert property (p_hold) else $error("stalled word not held");
    property p_take; $rose(sample_out_valid) |-> sample_out_bus == $past(raw_samples) && $past(raw_valid); endproperty
    a_take: assert property (p_take) else $error("output word wrong");

    // error pulses and interrupt
    property p_pulse; receive_reset_low |=> checksum_error == $past(checksum_detect)
        && command_parity_error == $past(parity_detect); endproperty
    a_pulse: assert property (p_pulse) else $error("error pulse wrong");
    property p_irq; checksum_error |-> ##[0:3] error_interrupt; endproperty
    a_irq: assert property (p_irq) else $error("no interrupt");
endmodule

bind rx_link_status rx_link_checker #(.W(M*S*WM*N)) u_chk (.aclk, .aresetn, .receive_reset_low,
    .raw_samples, .raw_valid, .checksum_detect, .parity_detect, .header_lock_flag, .multiblock_lock_flag,
    .lanes_aligned_flag, .error_interrupt, .checksum_error, .command_parity_error, .sample_out_bus,
    .sample_out_valid, .sample_out_ready);
`default_nettype wire

// *** adc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// converter side: lanes, sysref, ramp data
// ------------------------------------------
module adc_model (
    input  wire logic   aclk,
    input  wire logic   run,
    input  wire logic   bad,
    input  wire logic   skew,
    input  wire logic   quiet,
    output logic        header_ok,
    output logic        mb_marker,
    output logic        sysref,
    output logic [47:0] samples,
    output logic [3:0]  ctrl,
    output logic        valid
);
    localparam logic [7:0] RAMP_MODE = 8'h04;
    localparam logic [7:0] TSTAMP_RX = 8'h03;
    logic [2:0]  ref_q  = 3'h0;
    logic [2:0]  lemc_q = 3'h0;
    logic [11:0] ramp_q = 12'h0;

    // ramp runs free so idle data keeps moving; skew slips the sysref source
    always_ff @(posedge aclk) begin
        ramp_q <= ramp_q + 12'h4;
        ref_q  <= !run ? 3'h0 : ref_q + {2'h0, !skew};
        lemc_q <= (!run || (ref_q == 3'h7 && !skew)) ? 3'h0 : lemc_q + 3'h1;
    end

    // link outputs; quiet clears every sample lsb
    assign header_ok = run;
    assign valid     = run;
    assign sysref    = run && ref_q < 3'h2;
    assign mb_marker = run && lemc_q == 3'h0;
    assign ctrl      = ramp_q[3:0];
    assign samples   = {ramp_q + 12'h3, ramp_q + 12'h2, ramp_q + 12'h1, ramp_q ^ {11'h0, bad}}
                     & ~(quiet ? 48'h001001001001 : 48'h0);
endmodule
`default_nettype wire

// *** jesd_rx_link_align_latency_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module jesd_rx_link_align_latency_tb;
    logic        aclk = 1'b0;
    logic        aresetn, receive_reset_low, lane_header_ok, lane_mb_marker, sysref_in, timestamp_marker_in;
    logic        raw_valid, checksum_detect, parity_detect, sample_out_ready, header_lock_flag;
    logic        multiblock_lock_flag, lanes_aligned_flag, error_interrupt, checksum_error, command_parity_error;
    logic        ramp_mismatch, sample_out_valid, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        run, bad, skew, quiet;
    logic [47:0] raw_samples, sample_out_bus;
    logic [3:0]  raw_control, control_bits_out, s_axi_wstrb;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rbd1, lat1, rbd2, lat2;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          fails, n_checks;

    always #50 aclk = ~aclk;

    rx_link_status #(.HDR_GOOD(4), .LEMC_PERIOD(8)) u_dut (.aclk, .aresetn, .receive_reset_low,
        .lane_header_ok, .lane_mb_marker, .sysref_in, .timestamp_marker_in, .raw_samples, .raw_control,
        .raw_valid, .checksum_detect, .parity_detect, .header_lock_flag, .multiblock_lock_flag,
        .lanes_aligned_flag, .error_interrupt, .checksum_error, .command_parity_error, .ramp_mismatch,
        .sample_out_bus, .control_bits_out, .sample_out_valid, .sample_out_ready, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    adc_model u_adc (.aclk, .run, .bad, .skew, .quiet, .header_ok(lane_header_ok), .mb_marker(lane_mb_marker),
        .sysref(sysref_in), .samples(raw_samples), .ctrl(raw_control), .valid(raw_valid));

    // ----------------------------------------
    // report, compare and bus tasks
    // ----------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tmo(input int i);
        if (i >= 200) begin
            cmp("wait bound", 0, 1);
            conclude();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 1; i < 200; i++) begin
            @(posedge aclk);
            if (s_axi_awready) break;
        end
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        for (; i < 200 && !s_axi_bvalid; i++) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(i);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        int i;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 1; i < 200; i++) begin
            @(posedge aclk);
            if (s_axi_arready) break;
        end
        s_axi_arvalid <= 1'b0;
        for (; i < 200 && !s_axi_rvalid; i++) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(i);
    endtask

    task automatic chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        logic [31:0] d;
        rd(a, d);
        cmp(nm, e, d & m);
    endtask
    task automatic wait_al;
        int i;
        for (i = 0; i < 200 && lanes_aligned_flag !== 1'b1; i++) @(posedge aclk);
        tmo(i);
    endtask

    // timestamp, lsbs masked ten cycles, read counts
    task automatic meas(output logic [31:0] rbd, output logic [31:0] lat);
        quiet <= 1'b1;
        timestamp_marker_in <= 1'b1;
        repeat (10) @(posedge aclk);
        quiet <= 1'b0;
        timestamp_marker_in <= 1'b0;
        repeat (20) @(posedge aclk);
        rd(12'h080, rbd);
        cmp("latency done", 1, rbd[3]);
        rbd = {23'h0, rbd[18:10]};
        rd(12'h084, lat);
        cmp("latency window", 1, lat[15:0] >= 5 && lat[15:0] <= 14);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {aresetn, receive_reset_low, run, bad, skew, quiet, timestamp_marker_in} = '0;
        {checksum_detect, parity_detect, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        sample_out_ready = 1'b1;
        s_axi_wstrb = 4'hf;
        fails = 0;
        n_checks = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        receive_reset_low <= 1'b1;
        cmp("sample width", 48, $bits(u_dut.sample_out_bus));
        cmp("control width", 4, $bits(u_dut.control_bits_out));
        chk(12'h054, 32'h4, 32'h4, "single detect armed");
        chk(12'h064, '1, 32'h1f, "error enable");
        chk(12'h100, '1, 32'h0, "unmapped read");
        cmp("unmapped read resp", 2'h2, r);
        wr(12'h100, 32'h1);
        cmp("unmapped write resp", 2'h2, r);
        run <= 1'b1;
        wait_al();
        repeat (12) @(posedge aclk);
        chk(12'h080, 32'h7, 32'h7, "lock flags");
        chk(12'h054, 32'h4, 32'h0, "single detect");
        chk(12'h060, '1, 32'h0, "error status");
        cmp("output valid", 1, sample_out_valid);
        sample_out_ready <= 1'b0;
        repeat (4) @(posedge aclk);
        cmp("control", sample_out_bus[3:0], control_bits_out);
        sample_out_ready <= 1'b1;
        meas(rbd1, lat1);
        receive_reset_low <= 1'b0;
        run <= 1'b0;
        repeat (4) @(posedge aclk);
        cmp("reset flags", 4'h0, {header_lock_flag, multiblock_lock_flag, lanes_aligned_flag, sample_out_valid});
        receive_reset_low <= 1'b1;
        run <= 1'b1;
        wait_al();
        meas(rbd2, lat2);
        cmp("rbd repeat", 1, rbd2 + 2 >= rbd1 && rbd1 + 2 >= rbd2);
        cmp("latency repeat", 1, lat2 + 2 >= lat1 && lat1 + 2 >= lat2);
        wr(12'h068, 32'h1);
        repeat (20) @(posedge aclk);
        cmp("ramp flag", 0, ramp_mismatch);
        cmp("interrupt", 0, error_interrupt);
        chk(12'h080, 32'h2, 32'h2, "multiblock lock held");
        bad <= 1'b1;
        checksum_detect <= 1'b1;
        @(posedge aclk);
        bad <= 1'b0;
        checksum_detect <= 1'b0;
        parity_detect <= 1'b1;
        @(posedge aclk);
        parity_detect <= 1'b0;
        repeat (6) @(posedge aclk);
        cmp("ramp flag", 1, ramp_mismatch);
        cmp("interrupt", 1, error_interrupt);
        chk(12'h060, '1, 32'h16, "error status");
        wr(12'h068, 32'h3);
        repeat (2) @(posedge aclk);
        cmp("ramp flag cleared", 0, ramp_mismatch);
        skew <= 1'b1;
        @(posedge aclk);
        skew <= 1'b0;
        repeat (20) @(posedge aclk);
        chk(12'h060, 32'h1, 32'h1, "sysref phase error");
        conclude();
    end
endmodule
`default_nettype wire
